// [hdl/timed_scan_sampler_fifo.sv]
// Purpose: scan triggering, oversampling sequencer and sample FIFO
// Assumes: one-cycle wr/rd strobes on the host port, ADC answers with a done pulse
// Notes:   counters are simplified rate generators loaded over the host port
`timescale 1ns/10ps
module timed_scan_sampler_fifo
   import scan_sampler_pkg::*;
#(
   parameter int DEPTH = 2048,
   parameter int AW    = 11
)(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire host_req_t  hostReq,
   output logic [7:0]      hostRdata,
   output logic            halfFullIrq,
   input  wire logic       extDelayed_n,
   input  wire logic       extScan_n,
   output logic            convStart,
   output logic [3:0]      muxChannel,
   input  wire adc_res_t   adcRes
);
   typedef struct packed {
      logic [7:0]  scanLim;
      logic [1:0]  ovs;
      logic        irqEn;
      logic [7:0]  ctrl1;
      logic [7:0]  ctrl2;
      logic [15:0] load1;
      logic [15:0] load2;
      logic [15:0] cnt1;
      logic [15:0] cnt2;
      logic [7:0]  loadLo;
      logic        loadSel;
      logic [2:0]  tbAcc;
      logic [2:0]  syncDel;
      logic [2:0]  syncExt;
      logic        armed;
      seq_t        seq;
      logic [3:0]  chan;
      logic [4:0]  ovsCnt;
      logic [7:0]  pace;
      logic [AW:0] wrPtr;
      logic [AW:0] rdPtr;
      logic [7:0]  hiLatch;
      logic [7:0]  rdata;
      logic        halfPrev;
      logic        irq;
      logic        convStart;
      logic [3:0]  mux;
   } state_t;

   state_t      st;
   state_t      next_st;
   logic [15:0] mem [DEPTH];
   logic [AW:0] level;
   logic        empty;
   logic        half;
   logic        full;
   logic        tbTick;
   logic        tick1;
   logic        tick2;
   logic        delFall;
   logic        extFall;
   logic        timedOn;
   logic        delayMode;
   logic        trigger;
   logic [4:0]  ovsTarget;
   logic        push;
   logic        pop;
   logic [7:0]  status;

   assign level     = st.wrPtr - st.rdPtr;
   assign empty     = (level == '0);
   assign half      = (level >= (AW+1)'(DEPTH / 2));
   assign full      = (level == (AW+1)'(DEPTH));
   assign timedOn   = (st.ctrl1 == CTRL1_ENABLE) && (st.ctrl2 == CTRL2_ENABLE);
   assign delayMode = (st.ctrl1 == CTRL1_ENABLE) && (st.ctrl2 == 8'h00);
   assign tbTick    = (st.tbAcc + TB_STEP) >= TB_MOD;
   assign tick1     = tbTick && (st.cnt1 <= 16'h0001);
   assign tick2     = tick1 && (st.cnt2 <= 16'h0001);
   // 3rd stage high and 2nd stage low counts as a falling edge
   assign delFall   = (st.syncDel[2:1] == 2'b10);
   assign extFall   = (st.syncExt[2:1] == 2'b10);
   // counter timeout and external edge may both start a scan when enabled
   assign trigger   = ((timedOn || (delayMode && st.armed)) && tick2)
                    || (timedOn && extFall);
   assign push      = (st.seq == STORE) && !full;
   assign pop       = hostReq.rd && (hostReq.addr == OFS_DATA_HI) && !empty;
   assign status    = {empty, 1'b0, half, 5'h00};

   always_comb
   begin
      case (st.ovs)
         2'd0: ovsTarget = 5'd1;
         2'd1: ovsTarget = 5'd2;
         2'd2: ovsTarget = 5'd8;
         default: ovsTarget = 5'd16;
      endcase
   end

   always_comb
   begin
      next_st = st;
      next_st.convStart = 1'b0;
      next_st.syncDel = {st.syncDel[1:0], extDelayed_n};
      next_st.syncExt = {st.syncExt[1:0], extScan_n};
      next_st.tbAcc = tbTick ? 3'(st.tbAcc + TB_STEP - TB_MOD) : 3'(st.tbAcc + TB_STEP);
      if (tbTick)
      begin
         next_st.cnt1 = (st.cnt1 <= 16'h0001) ? st.load1 : st.cnt1 - 16'h0001;
         if (tick1)
         begin
            next_st.cnt2 = (st.cnt2 <= 16'h0001) ? st.load2 : st.cnt2 - 16'h0001;
         end
      end
      if (delayMode && delFall)
      begin
         next_st.armed = 1'b1;
      end
      // sequencer: fixed pace between conversions
      case (st.seq)
         IDLE:
         begin
            if (trigger)
            begin
               next_st.chan   = st.scanLim[3:0];
               next_st.ovsCnt = 5'd0;
               next_st.pace   = 8'(PACE_CYCLES - 1);
               next_st.seq    = CONVERT;
            end
         end
         CONVERT:
         begin
            if (st.pace != 8'h00)
            begin
               next_st.pace = st.pace - 8'h01;
            end
            else
            begin
               next_st.mux       = st.chan;
               next_st.convStart = 1'b1;
               next_st.seq       = STORE;
            end
         end
         STORE:
         begin
            // waits for the result; a full store stalls the scan
            if (adcRes.done && !full)
            begin
               next_st.seq = ADVANCE;
            end
         end
         ADVANCE:
         begin
            next_st.pace = 8'(PACE_CYCLES - 2);
            next_st.seq  = CONVERT;
            if (st.ovsCnt + 5'd1 < ovsTarget)
            begin
               next_st.ovsCnt = st.ovsCnt + 5'd1;
            end
            else if (st.chan == st.scanLim[7:4])
            begin
               next_st.seq = IDLE;
            end
            else
            begin
               next_st.ovsCnt = 5'd0;
               next_st.chan   = st.chan + 4'd1;
            end
         end
         default:
         begin
            next_st.seq = IDLE;
         end
      endcase
      if (push && adcRes.done)
      begin
         next_st.wrPtr = st.wrPtr + (AW+1)'(1);
      end
      if (pop)
      begin
         next_st.rdPtr = st.rdPtr + (AW+1)'(1);
      end
      next_st.rdata = 8'h00;
      if (hostReq.rd)
      begin
         if (hostReq.addr == OFS_DATA_LO)
         begin
            next_st.rdata   = mem[st.rdPtr[AW-1:0]][7:0];
            next_st.hiLatch = mem[st.rdPtr[AW-1:0]][15:8];
         end
         else if (hostReq.addr == OFS_DATA_HI)
         begin
            next_st.rdata = st.hiLatch;
         end
         else if (hostReq.addr == OFS_STATUS)
         begin
            next_st.rdata = status;
         end
      end
      if (hostReq.wr)
      begin
         if (hostReq.addr == OFS_FIFO_RESET)
         begin
            next_st.rdPtr = st.wrPtr;
         end
         else if (hostReq.addr == OFS_SCAN_LIM)
         begin
            next_st.scanLim = hostReq.wdata;
         end
         else if (hostReq.addr == OFS_IRQ_EN)
         begin
            next_st.irqEn = (hostReq.wdata == IRQ_ENABLE);
         end
         else if (hostReq.addr == OFS_CNT1_LO || hostReq.addr == OFS_CNT2_LO)
         begin
            next_st.loadLo  = hostReq.wdata;
            next_st.loadSel = (hostReq.addr == OFS_CNT1_LO);
         end
         else if (hostReq.addr == OFS_CNT_HI)
         begin
            // high byte commits the pair to the counter whose low byte came last
            // and restarts it, so a new rate needs no wait for the old period
            if (st.loadSel)
            begin
               next_st.load1 = {hostReq.wdata, st.loadLo};
               next_st.cnt1  = {hostReq.wdata, st.loadLo};
            end
            else
            begin
               next_st.load2 = {hostReq.wdata, st.loadLo};
               next_st.cnt2  = {hostReq.wdata, st.loadLo};
            end
         end
         else if (hostReq.addr == OFS_CTRL1)
         begin
            next_st.ctrl1 = hostReq.wdata;
            next_st.armed = 1'b0;
         end
         else if (hostReq.addr == OFS_CTRL2)
         begin
            next_st.ctrl2 = hostReq.wdata;
         end
         else if (hostReq.addr == OFS_OVERSAMPLE)
         begin
            next_st.ovs = hostReq.wdata[1:0];
         end
      end
      next_st.halfPrev = half;
      next_st.irq = st.irqEn && half && !st.halfPrev;
   end

   always_ff @(posedge clock)
   begin
      if (push && adcRes.done)
      begin
         mem[st.wrPtr[AW-1:0]] <= adcRes.data;
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st         <= '0;
         st.seq     <= IDLE;
         st.syncDel <= 3'b111;
         st.syncExt <= 3'b111;
         st.load1   <= CNT_RESET;
         st.load2   <= CNT_RESET;
         st.cnt1    <= CNT_RESET;
         st.cnt2    <= CNT_RESET;
         st.ovs     <= OVS_RESET;
         st.scanLim <= SCAN_LIM_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign hostRdata   = st.rdata;
   assign halfFullIrq = st.irq;
   assign convStart   = st.convStart;
   assign muxChannel  = st.mux;

   chk_empty_flag: assert property (@(posedge clock) disable iff (!reset_n)
      status[7] == (level == '0)) else $error("empty flag wrong");
   chk_half_flag: assert property (@(posedge clock) disable iff (!reset_n)
      status[5] == (level >= (AW+1)'(DEPTH / 2))) else $error("half flag wrong");
   chk_irq_rise: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(half) && st.irqEn |=> halfFullIrq) else $error("irq missed");
   chk_irq_off: assert property (@(posedge clock) disable iff (!reset_n)
      !$past(st.irqEn) |-> !halfFullIrq) else $error("irq while disabled");
   chk_no_restart: assert property (@(posedge clock) disable iff (!reset_n)
      (st.seq != IDLE) && trigger |=> (st.chan == $past(st.chan)) || ($past(st.seq) == ADVANCE))
      else $error("restart");
   chk_pop_high: assert property (@(posedge clock) disable iff (!reset_n)
      (st.rdPtr != $past(st.rdPtr)) && !$past(hostReq.wr) |-> $past(pop))
      else $error("pop without high read");
   chk_stop_idle: assert property (@(posedge clock) disable iff (!reset_n)
      (st.seq == IDLE) && st.ctrl1 == 8'h00 && st.ctrl2 == 8'h00 |=> st.seq == IDLE)
      else $error("scan while stopped");
   chk_pace_gap: assert property (@(posedge clock) disable iff (!reset_n)
      convStart |=> !convStart [*8]) else $error("pace too fast");
endmodule : timed_scan_sampler_fifo

// [hdl/scan_sampler_pkg.sv]
// Purpose: shared constants and carriers for the timed scan sampler
// Assumes: 8-bit host port, 25 MHz core clock
// Notes:   offsets are byte addresses on the host port
package scan_sampler_pkg;
   localparam logic [4:0]  OFS_DATA_LO    = 5'h00;
   localparam logic [4:0]  OFS_DATA_HI    = 5'h01;
   localparam logic [4:0]  OFS_FIFO_RESET = 5'h01;
   localparam logic [4:0]  OFS_SCAN_LIM   = 5'h02;
   localparam logic [4:0]  OFS_STATUS     = 5'h08;
   localparam logic [4:0]  OFS_IRQ_EN     = 5'h0C;
   localparam logic [4:0]  OFS_CNT1_LO    = 5'h14;
   localparam logic [4:0]  OFS_CNT2_LO    = 5'h15;
   localparam logic [4:0]  OFS_CNT_HI     = 5'h16;
   localparam logic [4:0]  OFS_CTRL1      = 5'h1A;
   localparam logic [4:0]  OFS_CTRL2      = 5'h1E;
   localparam logic [4:0]  OFS_OVERSAMPLE = 5'h1F;
   localparam logic [7:0]  CTRL1_ENABLE   = 8'h10;
   localparam logic [7:0]  CTRL2_ENABLE   = 8'h40;
   localparam logic [7:0]  IRQ_ENABLE     = 8'h10;
   localparam int          STAT_EMPTY_BIT = 7;
   localparam int          STAT_HALF_BIT  = 5;
   localparam logic [7:0]  SCAN_LIM_RESET = 8'h00;
   localparam logic [1:0]  OVS_RESET      = 2'h0;
   localparam logic [15:0] CNT_RESET      = 16'hFFFF;
   localparam int          CLOCK_HZ       = 25_000_000;
   localparam int          TIMEBASE_HZ    = 10_000_000;
   localparam int          PACE_HZ        = 250_000;
   localparam int          PACE_CYCLES    = CLOCK_HZ / PACE_HZ;
   // 10 MHz timebase from 25 MHz: phase accumulator, step 2 of 5
   localparam logic [2:0]  TB_STEP        = 3'h2;
   localparam logic [2:0]  TB_MOD         = 3'h5;

   typedef enum logic [3:0] {
      IDLE    = 4'b0001,
      CONVERT = 4'b0010,
      STORE   = 4'b0100,
      ADVANCE = 4'b1000
   } seq_t;

   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } host_req_t;

   typedef struct packed {
      logic [15:0] data;
      logic        done;
   } adc_res_t;
endpackage : scan_sampler_pkg

// [tb/adc_model.sv]
// Purpose: converter stand-in answering each start pulse with a done pulse
// Assumes: one conversion in flight at a time
// Notes:   data is {channel, running count}; idle data toggles every cycle
`timescale 1ns/10ps
module adc_model
   import scan_sampler_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       convStart,
   input  wire logic [3:0] muxChannel,
   output adc_res_t        adcRes
);
   logic [11:0] cnt;
   logic [3:0]  delay;
   logic [3:0]  chan;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt    <= 12'h000;
         delay  <= 4'h0;
         chan   <= 4'h0;
         adcRes <= '0;
      end
      else
      begin
         adcRes.done <= 1'b0;
         // no stale result outside the done cycle
         adcRes.data <= ~adcRes.data;
         if (convStart)
         begin
            delay <= 4'h5;
            chan  <= muxChannel;
         end
         else if (delay == 4'h1)
         begin
            adcRes.done <= 1'b1;
            adcRes.data <= {chan, cnt};
            cnt         <= cnt + 12'h001;
            delay       <= 4'h0;
         end
         else if (delay != 4'h0)
            delay <= delay - 4'h1;
      end
   end
endmodule : adc_model

// [tb/timed_scan_sampler_fifo_test.sv]
// Purpose: self-checking bench for the scan sampler
// Assumes: store depth shrunk to 16 so half full is 8 samples
// Notes:   reset counter timeouts are far beyond the run, so scans come from edges until the last part loads a 5000-clock timeout
`timescale 1ns/10ps
module timed_scan_sampler_fifo_test;
   import scan_sampler_pkg::*;
   typedef struct packed {logic [7:0] val; logic [7:0] mask;} note_t;
   logic        clock, reset_n, extDelayed_n, extScan_n, halfFullIrq, convStart, rdTaken;
   host_req_t   hostReq;
   logic [7:0]  hostRdata;
   logic [3:0]  muxChannel, s, c;
   adc_res_t    adcRes;
   logic [15:0] lfsrVal;
   logic [11:0] expCnt;
   int          error_cnt, num_checks, cycles, convCnt, doneCnt, irqCnt, base, irq0;
   note_t       notes[$];
   note_t       n;

   always #20 clock = ~clock;
   timed_scan_sampler_fifo #(.DEPTH(16), .AW(4)) uut (.clock(clock), .reset_n(reset_n),
      .hostReq(hostReq), .hostRdata(hostRdata), .halfFullIrq(halfFullIrq),
      .extDelayed_n(extDelayed_n), .extScan_n(extScan_n), .convStart(convStart),
      .muxChannel(muxChannel), .adcRes(adcRes));
   adc_model adc (.clock(clock), .reset_n(reset_n), .convStart(convStart),
      .muxChannel(muxChannel), .adcRes(adcRes));

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   task automatic hostWr(input logic [4:0] a, input logic [7:0] d);
      @(negedge clock);
      hostReq = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(negedge clock);
      hostReq.wr = 1'b0;
   endtask : hostWr
   task automatic hostRd(input logic [4:0] a, input logic [7:0] v, input logic [7:0] m);
      @(negedge clock);
      hostReq = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      notes.push_back('{val: v, mask: m});
      @(negedge clock);
      hostReq.rd = 1'b0;
   endtask : hostRd
   // low byte first; the high-byte read pops
   task automatic readN(input int cnt, input logic [3:0] ch);
      repeat (cnt)
      begin
         hostRd(OFS_DATA_LO, expCnt[7:0], 8'hFF);
         hostRd(OFS_DATA_HI, {ch, expCnt[11:8]}, 8'hFF);
         expCnt++;
      end
   endtask : readN
   task automatic status(input logic empty, input logic half);
      hostRd(OFS_STATUS, {empty, 1'b0, half, 5'h00}, 8'hA0);
   endtask : status
   task automatic scanEdge;
      @(negedge clock);
      extScan_n = 1'b0;
      repeat (4) @(negedge clock);
      extScan_n = 1'b1;
   endtask : scanEdge
   task automatic waitDone(input int k);
      int t;
      t = doneCnt + k;
      repeat (6000)
      begin
         if (doneCnt >= t)
            break;
         @(negedge clock);
      end
      repeat (300) @(negedge clock);
   endtask : waitDone

   always @(posedge clock)
   begin
      rdTaken <= hostReq.rd;
      cycles++;
      if (convStart === 1'b1)
         convCnt++;
      if (adcRes.done === 1'b1)
         doneCnt++;
      if (halfFullIrq === 1'b1)
         irqCnt++;
      if (cycles >= 30000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   always @(negedge clock)
   begin
      if (rdTaken === 1'b1)
      begin
         n = notes.pop_front();
         check({8'h00, hostRdata & n.mask}, {8'h00, n.val & n.mask});
      end
   end

   initial
   begin
      clock = 0;
      hostReq = '0;
      extDelayed_n = 1'b1;
      extScan_n = 1'b1;
      reset_n = 1'b0;
      rdTaken = 1'b0;
      expCnt = 12'h000;
      repeat (20) @(posedge clock);
      @(negedge clock);
      reset_n = 1'b1;
      status(1'b1, 1'b0);
      hostRd(5'h03, 8'h00, 8'hFF);
      lfsrVal = lfsr(16'd14700);
      s = {2'b00, lfsrVal[1:0]};
      // x2 oversampling over three channels
      hostWr(OFS_SCAN_LIM, {s + 4'h2, s});
      hostWr(OFS_OVERSAMPLE, 8'h01);
      hostWr(OFS_CTRL1, CTRL1_ENABLE);
      hostWr(OFS_CTRL2, CTRL2_ENABLE);
      base = convCnt;
      repeat (300) @(negedge clock);
      check(16'(convCnt - base), 16'h0000);
      scanEdge();
      repeat (150) @(negedge clock);
      scanEdge();
      waitDone(6);
      check(16'(convCnt - base), 16'h0006);
      status(1'b0, 1'b0);
      for (int ch = 0; ch < 3; ch++)
         readN(2, s + 4'(ch));
      status(1'b1, 1'b0);
      hostWr(OFS_CTRL1, 8'h00);
      hostWr(OFS_CTRL2, 8'h00);
      scanEdge();
      repeat (400) @(negedge clock);
      check(16'(convCnt - base), 16'h0006);
      // delayed mode, not yet armed: no scan without the delayed edge
      hostWr(OFS_CTRL1, CTRL1_ENABLE);
      scanEdge();
      repeat (400) @(negedge clock);
      check(16'(convCnt - base), 16'h0006);
      hostWr(OFS_CTRL1, 8'h00);
      lfsrVal = lfsr(lfsrVal);
      c = lfsrVal[3:0];
      hostWr(OFS_IRQ_EN, IRQ_ENABLE);
      hostWr(OFS_SCAN_LIM, {c, c});
      hostWr(OFS_OVERSAMPLE, 8'h03);
      hostWr(OFS_CTRL1, CTRL1_ENABLE);
      hostWr(OFS_CTRL2, CTRL2_ENABLE);
      irq0 = irqCnt;
      scanEdge();
      waitDone(16);
      check(16'(irqCnt - irq0), 16'h0001);
      status(1'b0, 1'b1);
      readN(8, c);
      status(1'b0, 1'b1);
      readN(1, c);
      status(1'b0, 1'b0);
      readN(7, c);
      status(1'b1, 1'b0);
      hostWr(OFS_IRQ_EN, 8'h00);
      scanEdge();
      waitDone(16);
      check(16'(irqCnt - irq0), 16'h0001);
      readN(16, c);
      status(1'b1, 1'b0);
      // factors 100 and 20: timeout every 5000 clocks, far above one scan
      hostWr(OFS_CTRL2, 8'h00);
      hostWr(OFS_CTRL1, CTRL1_ENABLE);
      hostWr(OFS_OVERSAMPLE, 8'h00);
      hostWr(OFS_CNT1_LO, 8'h64);
      hostWr(OFS_CNT_HI, 8'h00);
      hostWr(OFS_CNT2_LO, 8'h14);
      hostWr(OFS_CNT_HI, 8'h00);
      base = convCnt;
      repeat (6000) @(negedge clock);
      check(16'(convCnt - base), 16'h0000);
      extDelayed_n = 1'b0;
      repeat (4) @(negedge clock);
      extDelayed_n = 1'b1;
      waitDone(1);
      check(16'(convCnt - base), 16'h0001);
      hostWr(OFS_CTRL1, 8'h00);
      hostWr(OFS_CTRL2, 8'h00);
      readN(1, c);
      status(1'b1, 1'b0);
      print_verdict();
   end
endmodule : timed_scan_sampler_fifo_test
